//--- bench/wsd_mcu.sv
// partner: external controller on the control pins
`timescale 1ns/1ns
module wsd_mcu (
    input  wire logic clk,
    input  wire logic powerdown_detect_pin_oe_n,
    input  wire logic want_active,
    input  wire logic want_rx,
    output logic      powerdown_detect_pin_i,
    output logic      rx_tx_select_i,
    output logic      modulation_select_i,
    output logic      tx_bit
);
    logic [7:0] lfsr_q = 8'h5a;
    // open drain with pull-up, held low to stay active
    assign powerdown_detect_pin_i = !(want_active || !powerdown_detect_pin_oe_n);
    // controller owns rx/tx, modulation and tx data
    assign rx_tx_select_i = want_rx;
    assign modulation_select_i = lfsr_q[0];
    assign tx_bit = lfsr_q[1];
    // changing pattern so stale data never looks valid
    always @(posedge clk) begin
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]};
    end
endmodule

//--- bench/wsd_top_tb.sv
// testbench: register rows, wake pulses, clock output, data pin
`timescale 1ns/1ns
module wsd_top_tb;
    import wsd_pkg::*;
    localparam int RCH = 4;
    typedef struct {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] m;} wsd_row_s;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, want_rx = 1, tx_bit;
    logic [7:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, block_enable_o, q;
    logic powerdown_detect_pin_i, powerdown_detect_pin_o, powerdown_detect_pin_oe_n;
    logic rx_tx_select_i, modulation_select_i, data_pin_i, data_pin_o, data_pin_oe_n;
    logic rx_data_i = 0, rssi_above_th3_i = 0, rate_in_window_i = 0;
    logic rate_in_half_window_i = 0, window_done_i = 0;
    logic tx_data_o, modulation_fsk_o, divided_clock_pin_o;
    int mismatches = 0, check_count = 0, cycles = 0, n, k;
    int gaps [3] = '{108, 6, RCH};
    wsd_row_s rows [18] = '{
        '{0, REG_CONFIG, 16'h0000, 16'hffff}, '{0, REG_ON_TIME, 16'h0020, 16'hffff},
        '{0, REG_OFF_TIME, 16'h0020, 16'hffff}, '{0, REG_CLK_DIV, 16'h0008, 16'hffff},
        '{0, REG_BLOCK_POWERDOWN, 16'hffff, 16'hffff}, '{0, 8'h33, 16'h0000, 16'hffff},
        '{1, REG_CLK_DIV, 16'h00ff, 0}, '{0, REG_CLK_DIV, 16'h003f, 16'hffff},
        '{1, REG_CLK_DIV, 16'h0008, 0}, '{1, REG_CONFIG, 16'h0001, 0},
        '{0, REG_STATUS, 16'h0040, 16'h00c0}, '{1, REG_CONFIG, 16'h0002, 0},
        '{0, REG_STATUS, 16'h00c0, 16'h00c0}, '{1, REG_CONFIG, 16'h0003, 0},
        '{0, REG_STATUS, 16'h00c0, 16'h00c0}, '{1, REG_CONFIG, 16'h0000, 0},
        '{1, REG_STATUS, 16'hffff, 0}, '{0, REG_STATUS, 16'h0000, 16'h00c0}};
    assign data_pin_i = data_pin_oe_n ? tx_bit : data_pin_o;
    wsd_top #(.RC_HALF(RCH)) wsd_top_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .powerdown_detect_pin_i, .powerdown_detect_pin_o,
        .powerdown_detect_pin_oe_n, .rx_tx_select_i, .modulation_select_i, .data_pin_i,
        .data_pin_o, .data_pin_oe_n, .rx_data_i, .rssi_above_th3_i, .rate_in_window_i,
        .rate_in_half_window_i, .window_done_i, .tx_data_o, .modulation_fsk_o,
        .block_enable_o, .divided_clock_pin_o);
    wsd_mcu wsd_mcu_i (.clk, .powerdown_detect_pin_oe_n, .want_active(1'b1), .want_rx,
        .powerdown_detect_pin_i, .rx_tx_select_i, .modulation_select_i, .tx_bit);
    always #2 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] r);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    // cycles until the wake pin output leaves the given level
    task automatic span(input logic lvl, output int c);
        c = 0;
        while (powerdown_detect_pin_oe_n === lvl && c < 9000) begin
            @(posedge clk);
            #1 c++;
        end
    endtask
    // length of the first full half period seen on the clock pin
    task automatic gap(output int c);
        logic v;
        for (int i = 0; i < 2; i++) begin
            v = divided_clock_pin_o;
            c = 0;
            while (divided_clock_pin_o === v && c < 3000) begin
                @(posedge clk);
                #1 c++;
            end
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (120) begin
            @(posedge clk);
            #1 chk({divided_clock_pin_o, powerdown_detect_pin_oe_n}, 16'h1);
        end
        $display("boot test done");
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, q);
                chk(q & rows[i].m, rows[i].d);
            end
        end
        $display("register rows done");
        for (k = 0; k < 3; k++) begin
            wr(REG_CLK_DIV, 16'h0008 | 16'(k << 4));
            gap(n);
            chk(16'(n), 16'(gaps[k]));
        end
        wr(REG_CLK_DIV, 16'h0008);
        $display("clock select test done");
        for (k = 0; k < 6; k++) begin
            wr(REG_CONFIG, (k < 2) ? 16'h0000 : (k < 4) ? 16'h0008 : 16'h000c);
            rx_data_i <= k[0];
            repeat (3) @(posedge clk);
            #1 chk({data_pin_oe_n, data_pin_o}, 16'(k > 1 && (k[0] ^ (k > 3))));
        end
        $display("data pin test done");
        wr(REG_BLOCK_POWERDOWN, 16'ha5a5);
        wr(REG_CONFIG, 16'h0010);
        repeat (4) @(posedge clk);
        #1 chk(block_enable_o, 16'h5a5a);
        $display("test mode done");
        wr(REG_ON_TIME, 16'h0100);
        wr(REG_OFF_TIME, 16'h0100);
        wr(REG_CONFIG, 16'h0001);
        span(1'b1, n);
        span(1'b0, n);
        chk(16'(n), 16'(PULSE_CYC));
        span(1'b1, n);
        chk(16'(n), 16'(512 * 2 * RCH - PULSE_CYC));
        $display("timer pulse test done");
        // one-shot: a second decision in the same on interval is refused
        wr(REG_ON_TIME, 16'h0800);
        wr(REG_CONFIG, 16'h0002);
        span(1'b0, n);
        for (k = 0; k < 3; k++) begin
            if (k == 2) begin
                wr(REG_CONFIG, 16'h0062);
            end
            @(posedge clk);
            {rssi_above_th3_i, rate_in_window_i, window_done_i} <= 3'h7;
            @(posedge clk);
            window_done_i <= 1'b0;
            #1 chk(16'(powerdown_detect_pin_oe_n), 16'(k == 1));
            span(1'b0, n);
        end
        $display("polling pulse test done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(REG_CONFIG, q);
        chk(q, 16'h0000);
        $display("reset test done");
        wrap_up();
    end
endmodule

//--- rtl/wsd_clk_div.sv
// clock output divider and source selector
`timescale 1ns/1ns
module wsd_clk_div
    import wsd_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    wsd_div_if.div    dif
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic       out_q;
    logic       out_d;
    logic [4:0] limit;

    always_comb begin
        // half periods of the output, counted in crystal half periods
        limit = {dif.ratio, 1'b1};
        cnt_d = cnt_q;
        out_d = out_q;
        if (!dif.run) begin
            cnt_d = 5'h00;
            out_d = 1'b0;
        end else begin
            unique case (dif.sel)
                SEL_DIV: begin
                    // ratio of twice field plus two
                    if (dif.xtal_half) begin
                        if (cnt_q >= limit) begin
                            cnt_d = 5'h00;
                            out_d = ~out_q;
                        end else begin
                            cnt_d = cnt_q + 5'h01;
                        end
                    end
                end
                SEL_XTAL: if (dif.xtal_half) out_d = ~out_q;
                SEL_RC:   if (dif.rc_half) out_d = ~out_q;
                SEL_WIN:  out_d = dif.win_done;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 5'h00;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign dif.clk_out = out_q;

    default clocking dcb @(posedge clk); endclocking
    default disable iff (sys_rst);

    div_toggle_a: assert property (
        $past(dif.run) && dif.run && $past(dif.sel) == SEL_DIV && $changed(out_q)
        |-> $past(cnt_q) == {$past(dif.ratio), 1'b1})
        else $error("divider toggled at wrong count");
    div_stop_a: assert property (
        !dif.run |=> !out_q)
        else $error("clock output ran while stopped");
endmodule

//--- rtl/wsd_div_if.sv
// interface: settings and ticks from the sequencer to the clock output divider
`timescale 1ns/1ns
interface wsd_div_if;
    logic [1:0] sel;
    logic [3:0] ratio;
    logic       run;
    logic       xtal_half;
    logic       rc_half;
    logic       win_done;
    logic       clk_out;
    modport top (output sel, ratio, run, xtal_half, rc_half, win_done, input clk_out);
    modport div (input sel, ratio, run, xtal_half, rc_half, win_done, output clk_out);
endinterface

//--- rtl/wsd_pkg.sv
// package: register map, field positions, modes and timing constants of the sequencer
package wsd_pkg;
    // clock and time base
    localparam int CLK_HZ        = 250000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int XTAL_HZ       = 18089000;
    localparam int XTAL_HALF_CYC = CLK_HZ / (2 * XTAL_HZ);
    localparam int RC_STEP_NS    = 31250;
    localparam int RC_HALF_NS    = RC_STEP_NS / 2;
    localparam int RC_HALF_CYC   = RC_HALF_NS / CLK_PERIOD_NS;
    localparam int PULSE_NS      = 15000;
    localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GUARD_CYC     = 4;
    localparam int DD_SETUP_US   = 2600;
    localparam int CLK_SETUP_US  = 500;

    function automatic int steps_of(input int us);
        steps_of = (us * 1000 + RC_STEP_NS - 1) / RC_STEP_NS;
    endfunction

    localparam logic [15:0] DD_STEPS     = 16'(steps_of(DD_SETUP_US));
    localparam logic [15:0] CLK_SU_STEPS = 16'(steps_of(CLK_SETUP_US));

    // register offsets
    localparam logic [7:0] REG_CONFIG   = 8'h00;
    localparam logic [7:0] REG_ON_TIME  = 8'h04;
    localparam logic [7:0] REG_OFF_TIME = 8'h05;
    localparam logic [7:0] REG_CLK_DIV  = 8'h0d;
    localparam logic [7:0] REG_BLOCK_POWERDOWN = 8'h0f;
    localparam logic [7:0] REG_STATUS   = 8'h82;

    // reset values
    localparam logic [15:0] CONFIG_RST   = 16'h0000;
    localparam logic [15:0] ON_TIME_RST  = 16'h0020;
    localparam logic [15:0] OFF_TIME_RST = 16'h0020;
    localparam logic [7:0]  CLK_DIV_RST  = 8'h08;
    localparam logic [15:0] BLOCK_POWERDOWN_RST = 16'hffff;

    // config and clock divider fields
    localparam int CFG_MODE2_BIT    = 0;
    localparam int CFG_MODE1_BIT    = 1;
    localparam int CFG_INV_BIT      = 2;
    localparam int CFG_DOUT_BIT     = 3;
    localparam int CFG_TEST_BIT     = 4;
    localparam int CFG_ADC_CONT_BIT = 5;
    localparam int CFG_WIN_CONT_BIT = 6;
    localparam int CFG_HALF_BIT     = 7;
    localparam int CFG_CLKEN_BIT    = 9;
    localparam int DIV_RATIO_LSB    = 0;
    localparam int DIV_SEL_LSB      = 4;

    // block enable positions, same layout as the block power-down register
    localparam logic [15:0] BLK_REF    = 16'h8000;
    localparam logic [15:0] BLK_RC     = 16'h4000;
    localparam logic [15:0] BLK_DETECT = 16'h3000;
    localparam logic [15:0] BLK_RX     = 16'h0ff8;
    localparam logic [15:0] BLK_PA     = 16'h0004;
    localparam logic [15:0] BLK_PLL    = 16'h0002;
    localparam logic [15:0] BLK_XTAL   = 16'h0001;

    typedef enum logic [1:0] {
        MODE_SLAVE = 2'b00,
        MODE_TIMER = 2'b01,
        MODE_POLL  = 2'b11
    } wsd_mode_e;

    typedef enum logic [1:0] {
        SEQ_BOOT  = 2'b00,
        SEQ_SETUP = 2'b01,
        SEQ_RUN   = 2'b11
    } wsd_seq_e;

    typedef enum logic [1:0] {
        SEL_DIV  = 2'b00,
        SEL_XTAL = 2'b01,
        SEL_RC   = 2'b10,
        SEL_WIN  = 2'b11
    } wsd_sel_e;

    function automatic wsd_mode_e mode_of(input logic m1, input logic m2);
        mode_of = m1 ? MODE_POLL : (m2 ? MODE_TIMER : MODE_SLAVE);
    endfunction
endpackage

//--- rtl/wsd_top.sv
// top: wakeup modes, data valid routing, power-up sequencer and register port
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module wsd_top
    import wsd_pkg::*;
#(
    parameter int RC_HALF        = RC_HALF_CYC,
    parameter int SYS_SETUP_US   = 1000,
    parameter int TX_SETUP_US    = 500
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        powerdown_detect_pin_i,
    output logic             powerdown_detect_pin_o,
    output logic             powerdown_detect_pin_oe_n,
    input  wire logic        rx_tx_select_i,
    input  wire logic        modulation_select_i,
    input  wire logic        data_pin_i,
    output logic             data_pin_o,
    output logic             data_pin_oe_n,
    input  wire logic        rx_data_i,
    input  wire logic        rssi_above_th3_i,
    input  wire logic        rate_in_window_i,
    input  wire logic        rate_in_half_window_i,
    input  wire logic        window_done_i,
    output logic             tx_data_o,
    output logic             modulation_fsk_o,
    output logic      [15:0] block_enable_o,
    output logic             divided_clock_pin_o
);
    localparam logic [15:0] SYS_STEPS = 16'(steps_of(SYS_SETUP_US));
    localparam logic [15:0] TX_STEPS  = 16'(steps_of(TX_SETUP_US));
    localparam logic [11:0] PULSE_LEN = 12'(PULSE_CYC);
    localparam logic [11:0] RC_LAST   = 12'(RC_HALF - 1);
    localparam logic [3:0]  XT_LAST   = 4'(XTAL_HALF_CYC - 1);
    localparam logic [2:0]  GUARD_LEN = 3'(GUARD_CYC);

    // pins pass two flops; only the second stage is read
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
        end else begin
            s1_q <= {powerdown_detect_pin_i, rx_tx_select_i, modulation_select_i, data_pin_i};
            s2_q <= s1_q;
        end
    end
    logic pd_s;
    logic rxsel_s;
    logic mod_s;
    logic data_s;
    assign {pd_s, rxsel_s, mod_s, data_s} = s2_q;

    // registers
    logic [15:0] cfg_q, cfg_d, on_q, on_d, off_q, off_d, blkpd_q, blkpd_d, rdata_d;
    logic [7:0]  div_q, div_d;
    logic [15:0] status;

    always_comb begin
        cfg_d   = cfg_q;
        on_d    = on_q;
        off_d   = off_q;
        blkpd_d = blkpd_q;
        div_d   = div_q;
        if (reg_wr) begin
            unique case (reg_addr)
                REG_CONFIG:   cfg_d = reg_wdata;
                REG_ON_TIME:  on_d = reg_wdata;
                REG_OFF_TIME: off_d = reg_wdata;
                REG_BLOCK_POWERDOWN: blkpd_d = reg_wdata;
                REG_CLK_DIV:  div_d = {2'b00, reg_wdata[5:0]};
                default:      cfg_d = cfg_q;
            endcase
        end
        rdata_d = reg_rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CONFIG:   rdata_d = cfg_q;
                REG_ON_TIME:  rdata_d = on_q;
                REG_OFF_TIME: rdata_d = off_q;
                REG_BLOCK_POWERDOWN: rdata_d = blkpd_q;
                REG_CLK_DIV:  rdata_d = {8'h00, div_q};
                REG_STATUS:   rdata_d = status;
                default:      rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_q     <= CONFIG_RST;
            on_q      <= ON_TIME_RST;
            off_q     <= OFF_TIME_RST;
            blkpd_q   <= BLOCK_POWERDOWN_RST;
            div_q     <= CLK_DIV_RST;
            reg_rdata <= 16'h0000;
        end else begin
            cfg_q     <= cfg_d;
            on_q      <= on_d;
            off_q     <= off_d;
            blkpd_q   <= blkpd_d;
            div_q     <= div_d;
            reg_rdata <= rdata_d;
        end
    end

    // time base: rc half ticks, 31.25us steps, crystal half ticks
    logic [11:0] rc_cnt_q, rc_cnt_d;
    logic [3:0]  xt_cnt_q, xt_cnt_d;
    logic        rc_ph_q, rc_ph_d, rc_half, xt_half, step;
    always_comb begin
        rc_half  = (rc_cnt_q == RC_LAST);
        xt_half  = (xt_cnt_q == XT_LAST);
        rc_cnt_d = rc_half ? 12'h000 : rc_cnt_q + 12'h001;
        xt_cnt_d = xt_half ? 4'h0 : xt_cnt_q + 4'h1;
        rc_ph_d  = rc_half ? ~rc_ph_q : rc_ph_q;
        step     = rc_half & rc_ph_q;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rc_cnt_q <= 12'h000;
            xt_cnt_q <= 4'h0;
            rc_ph_q  <= 1'b0;
        end else begin
            rc_cnt_q <= rc_cnt_d;
            xt_cnt_q <= xt_cnt_d;
            rc_ph_q  <= rc_ph_d;
        end
    end

    // mode, on/off timer, wake pulse
    wsd_mode_e   mode_q, mode_d;
    logic        phase_on_q, phase_on_d, cycle_end, shot_q, shot_d;
    logic [15:0] tmr_q, tmr_d;
    logic [11:0] pulse_q, pulse_d;
    logic [2:0]  guard_q, guard_d;
    logic        pin_act, active, rx, tx, valid, dd_ready, tx_ready, pulse_req, cont;

    always_comb begin
        mode_d     = mode_of(cfg_q[CFG_MODE1_BIT], cfg_q[CFG_MODE2_BIT]);
        phase_on_d = phase_on_q;
        tmr_d      = tmr_q;
        cycle_end  = 1'b0;
        if (mode_q == MODE_SLAVE) begin
            phase_on_d = 1'b1;
            tmr_d      = 16'h0000;
        end else if (step) begin
            tmr_d = tmr_q + 16'h0001;
            if (phase_on_q && tmr_d >= on_q) begin
                tmr_d      = 16'h0000;
                phase_on_d = (off_q == 16'h0000);
                cycle_end  = (off_q == 16'h0000);
            end else if (!phase_on_q && tmr_d >= off_q) begin
                tmr_d      = 16'h0000;
                phase_on_d = (on_q != 16'h0000);
                cycle_end  = 1'b1;
            end
        end
        // window done, rssi, rate window and detection setup give valid
        valid = window_done_i & rssi_above_th3_i & dd_ready
              & (cfg_q[CFG_HALF_BIT] ? rate_in_half_window_i : rate_in_window_i);
        // continuous only with both bits set
        cont = cfg_q[CFG_ADC_CONT_BIT] & cfg_q[CFG_WIN_CONT_BIT];
        pulse_req = (mode_q == MODE_TIMER && cycle_end)
                  // one-shot allows one per on interval
                  | (mode_q == MODE_POLL && valid && (cont || !shot_q));
        // set wins over the clear at a new cycle
        shot_d = pulse_req | (shot_q & !cycle_end & (mode_q == MODE_POLL));
        pulse_d = pulse_q;
        guard_d = guard_q;
        if (pulse_q != 12'h000) begin
            pulse_d = pulse_q - 12'h001;
            guard_d = GUARD_LEN;
        end else if (pulse_req) begin
            pulse_d = PULSE_LEN;
        end else if (guard_q != 3'h0) begin
            guard_d = guard_q - 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q     <= MODE_SLAVE;
            phase_on_q <= 1'b1;
            tmr_q      <= 16'h0000;
            shot_q     <= 1'b0;
            pulse_q    <= 12'h000;
            guard_q    <= 3'h0;
        end else begin
            mode_q     <= mode_d;
            phase_on_q <= phase_on_d;
            tmr_q      <= tmr_d;
            shot_q     <= shot_d;
            pulse_q    <= pulse_d;
            guard_q    <= guard_d;
        end
    end

    // own pulse echoes back through the synchroniser, so the pin is ignored meanwhile
    assign pin_act = !pd_s && pulse_q == 12'h000 && guard_q == 3'h0;
    // slave and timer modes follow the pins
    assign active  = (mode_q == MODE_POLL) ? phase_on_q : pin_act;
    assign rx      = (mode_q == MODE_POLL) ? 1'b1 : rxsel_s;
    assign tx      = active & !rx;

    // sequencer
    wsd_seq_e    seq_q, seq_d;
    logic [15:0] seq_cnt_q, seq_cnt_d, su_cnt_q, su_cnt_d, dd_cnt_q, dd_cnt_d;
    logic [15:0] tx_cnt_q, tx_cnt_d, en_d;
    logic        clk_ready, clk_run_d, clk_run_q, data_o_d, data_oe_n_d, tx_data_d;

    always_comb begin
        seq_d     = seq_q;
        seq_cnt_d = seq_cnt_q;
        unique case (seq_q)
            SEQ_BOOT: if (pin_act) seq_d = SEQ_SETUP;
            SEQ_SETUP: begin
                if (step && active) seq_cnt_d = seq_cnt_q + 16'h0001;
                if (seq_cnt_q >= SYS_STEPS) seq_d = SEQ_RUN;
            end
            SEQ_RUN: seq_cnt_d = seq_cnt_q;
        endcase
        clk_ready = (su_cnt_q >= CLK_SU_STEPS);
        su_cnt_d  = (step && !clk_ready) ? su_cnt_q + 16'h0001 : su_cnt_q;
        dd_cnt_d = dd_cnt_q;
        tx_cnt_d = tx_cnt_q;
        if (!(active && rx) || seq_q != SEQ_RUN) dd_cnt_d = 16'h0000;
        else if (step && !dd_ready) dd_cnt_d = dd_cnt_q + 16'h0001;
        if (!tx || seq_q != SEQ_RUN) tx_cnt_d = 16'h0000;
        else if (step && !tx_ready) tx_cnt_d = tx_cnt_q + 16'h0001;
        // polling clock gated by on interval
        // clock enable keeps it running in powerdown
        clk_run_d = clk_ready & (cfg_q[CFG_CLKEN_BIT] | seq_q != SEQ_RUN
                  | ((mode_q == MODE_POLL) ? (phase_on_q & pd_s) : active));
        en_d = BLK_RC;
        if (clk_run_d) en_d = en_d | BLK_REF | BLK_XTAL;
        if (active && rx) en_d = en_d | BLK_REF | BLK_XTAL | BLK_PLL | BLK_RX;
        if (active && rx && dd_ready) en_d = en_d | BLK_DETECT;
        if (tx) en_d = en_d | BLK_REF | BLK_XTAL | BLK_PLL;
        if (tx && tx_ready) en_d = en_d | BLK_PA;
        if (cfg_q[CFG_TEST_BIT]) en_d = ~blkpd_q;
        data_o_d    = 1'b0;
        data_oe_n_d = 1'b0;
        tx_data_d   = 1'b0;
        if (tx) begin
            data_oe_n_d = 1'b1;
            tx_data_d   = data_s;
        end else if (active && cfg_q[CFG_DOUT_BIT]) begin
            data_o_d = rx_data_i ^ cfg_q[CFG_INV_BIT];
        end
    end
    assign dd_ready = (dd_cnt_q >= DD_STEPS);
    assign tx_ready = (tx_cnt_q >= TX_STEPS);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_q                     <= SEQ_BOOT;
            seq_cnt_q                 <= 16'h0000;
            su_cnt_q                  <= 16'h0000;
            dd_cnt_q                  <= 16'h0000;
            tx_cnt_q                  <= 16'h0000;
            clk_run_q                 <= 1'b0;
            block_enable_o            <= BLK_RC;
            data_pin_o                <= 1'b0;
            data_pin_oe_n             <= 1'b0;
            tx_data_o                 <= 1'b0;
            modulation_fsk_o          <= 1'b0;
            powerdown_detect_pin_oe_n <= 1'b1;
        end else begin
            seq_q                     <= seq_d;
            seq_cnt_q                 <= seq_cnt_d;
            su_cnt_q                  <= su_cnt_d;
            dd_cnt_q                  <= dd_cnt_d;
            tx_cnt_q                  <= tx_cnt_d;
            clk_run_q                 <= clk_run_d;
            block_enable_o            <= en_d;
            data_pin_o                <= data_o_d;
            data_pin_oe_n             <= data_oe_n_d;
            tx_data_o                 <= tx_data_d;
            modulation_fsk_o          <= mod_s;
            powerdown_detect_pin_oe_n <= (pulse_d == 12'h000);
        end
    end
    assign powerdown_detect_pin_o = 1'b0;

    assign status = {6'h00, seq_q, mode_q, phase_on_q, clk_run_q,
                     dd_ready, tx_ready, active, rx};

    wsd_div_if div_if ();
    assign div_if.sel       = div_q[DIV_SEL_LSB +: 2];
    assign div_if.ratio     = div_q[DIV_RATIO_LSB +: 4];
    assign div_if.run       = clk_run_q;
    assign div_if.xtal_half = xt_half;
    assign div_if.rc_half   = rc_half;
    assign div_if.win_done  = window_done_i;

    wsd_clk_div u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .dif     (div_if.div)
    );
    assign divided_clock_pin_o = div_if.clk_out;

    // low-time counter on the wake pin, read only by the checks below
    logic [11:0] low_cnt_q;
    always_ff @(posedge clk) begin
        if (sys_rst) low_cnt_q <= 12'h000;
        else low_cnt_q <= powerdown_detect_pin_oe_n ? 12'h000 : low_cnt_q + 12'h001;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    mode_decode_a: assert property (
        $changed(cfg_q[1:0])
        |=> mode_q == mode_of($past(cfg_q[CFG_MODE1_BIT]), $past(cfg_q[CFG_MODE2_BIT])))
        else $error("mode does not follow mode bits");
    slave_quiet_a: assert property (
        mode_q == MODE_SLAVE && $past(mode_q) == MODE_SLAVE && pulse_q == 12'h000
        |=> powerdown_detect_pin_oe_n)
        else $error("wake pulse in slave mode");
    pulse_width_a: assert property (
        $rose(powerdown_detect_pin_oe_n) |-> low_cnt_q == PULSE_LEN)
        else $error("wake pulse has wrong length");
    timer_pulse_a: assert property (
        mode_q == MODE_TIMER && cycle_end && pulse_q == 12'h000 |=> !powerdown_detect_pin_oe_n)
        else $error("timer cycle gave no pulse");
    one_shot_a: assert property (
        mode_q == MODE_POLL && !cont && shot_q && !cycle_end |=> !$rose(pulse_q != 12'h000))
        else $error("second pulse in one on interval");
    data_ground_a: assert property (
        !tx && !(active && cfg_q[CFG_DOUT_BIT]) && !cfg_q[CFG_TEST_BIT]
        |=> !data_pin_oe_n && !data_pin_o)
        else $error("data pin not grounded");
    test_override_a: assert property (
        cfg_q[CFG_TEST_BIT] |=> block_enable_o == ~$past(blkpd_q))
        else $error("test mode enables wrong");
    pa_setup_a: assert property (
        !cfg_q[CFG_TEST_BIT] && en_d[2] |-> tx_cnt_q >= TX_STEPS)
        else $error("amplifier enabled before setup");
    detect_setup_a: assert property (
        !cfg_q[CFG_TEST_BIT] && en_d[12] |-> dd_cnt_q >= DD_STEPS)
        else $error("detection enabled before setup");
    clk_setup_a: assert property (
        su_cnt_q < CLK_SU_STEPS |=> !clk_run_q)
        else $error("clock out before setup time");
endmodule
